// File: verilog/pianr_pkg.sv
// How it works
// R1 - identifier high register read-only, sixteen upper identifier bits
// R2 - identifier low bits 15:10 hold remaining six identifier bits, read-only
// R3 - identifier low register bits 9:4 hold a fixed read-only model number
// R4 - identifier low register bits 3:0 hold a fixed read-only revision
// R5 - advertisement next-page bit and reserved bit 14 always read zero
// R6 - advertisement remote-fault bit 13 read/write, resets zero, advertised
// R7 - technology ability field resets from local status ability bits
// R8 - advertisement writes stored, only advertised after negotiation restart
// R9 - asymmetric pause bit 11 and pause bit 10 read/write, reset zero
// R10 - advertisement bits 12 and 9 are read-only zero
// R11 - ability bits 8:5 reset to one and are writable
// R12 - advertisement selector bits 4:0 read-only, return 802.3 code 00001
// R13 - partner register reports next-page, acknowledge and remote fault read-only
// R14 - partner register shows abilities 12:5 and selector 4:0, reset zero
// R15 - partner register holds next-page message layout for next pages
// R16 - expansion parallel-detect fault bit 4 latches high, cleared by read
// R17 - expansion bit 3 partner next-page able, bit 2 zero, 15:5 zero
// R18 - expansion page-received bit 1 latches on new word, cleared by read
// R19 - expansion bit 0 shows partner negotiation capability
// R20 - local status ability bits 15:11 are fixed, ignore control changes
// R21 - registers at indexes two to six; only reads of the expansion register clear its latched flags
package pianr_pkg;

   // -----------------------------------------------------------------
   // register indexes, byte address is four times the index
   // -----------------------------------------------------------------
   localparam logic [5:0] IDX_ID_HIGH = 6'h02;
   localparam logic [5:0] IDX_ID_LOW  = 6'h03;
   localparam logic [5:0] IDX_ADV     = 6'h04;
   localparam logic [5:0] IDX_LPA     = 6'h05;
   localparam logic [5:0] IDX_EXP     = 6'h06;

   // -----------------------------------------------------------------
   // identity values, arbitrary neutral codes
   // -----------------------------------------------------------------
   localparam logic [15:0] ID_OUI_HIGH = 16'h0a5a;
   localparam logic [5:0]  ID_OUI_LOW  = 6'h15;
   localparam logic [5:0]  ID_MODEL    = 6'h2a;
   localparam logic [3:0]  ID_REV      = 4'h1;

   // -----------------------------------------------------------------
   // advertisement layout
   // -----------------------------------------------------------------
   localparam logic [4:0]  LOCAL_ABILITY = 5'h0f;
   localparam int          ADV_RF_BIT    = 13;
   localparam int          ADV_ASYM_BIT  = 11;
   localparam int          ADV_PAUSE_BIT = 10;
   localparam logic [4:0]  SEL_8023      = 5'h01;
   localparam logic [15:0] ADV_WR_MASK   = 16'h2de0;
   localparam logic [15:0] ADV_RESET     = {7'h00, LOCAL_ABILITY[3:0], 5'h00};

   // -----------------------------------------------------------------
   // expansion layout
   // -----------------------------------------------------------------
   localparam int EXP_PDF_BIT   = 4;
   localparam int EXP_LPNP_BIT  = 3;
   localparam int EXP_PRX_BIT   = 1;
   localparam int EXP_LPAN_BIT  = 0;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed
   {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } pianr_wb_req_t;

   typedef struct packed
   {
      logic        word_valid;
      logic [15:0] word;
      logic        parallel_fault;
      logic        an_able;
      logic        np_able;
      logic        restart;
   } pianr_an_evt_t;

endpackage

// File: verilog/pianr_regs.sv
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module pianr_regs
(
   // clock and reset
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_rst_n,
   // wishbone slave
   input  wire pianr_pkg::pianr_wb_req_t i_wb,
   output logic                        o_wb_ack,
   output logic [31:0]                 o_wb_dat,
   // negotiation engine
   input  wire pianr_pkg::pianr_an_evt_t i_an,
   output logic [15:0]                 o_adv_word,
   output logic [4:0]                  o_status_ability
);
   import pianr_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic        ack_r;
   logic [31:0] dat_r;
   logic [15:0] adv_r;
   logic [15:0] adv_nxt;
   logic [15:0] act_r;
   logic [15:0] lpa_r;
   logic        pdf_r;
   logic        pdf_nxt;
   logic        prx_r;
   logic        prx_nxt;
   logic [4:0]  stat_r;

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire         req      = i_wb.cyc & i_wb.stb & ~ack_r;
   wire [5:0]   idx      = i_wb.adr[7:2];
   wire         wr       = req & i_wb.we;
   wire         rd       = req & ~i_wb.we;
   wire         hit_adv  = (idx == IDX_ADV);
   wire         hit_exp  = (idx == IDX_EXP);
   wire [15:0]  be_mask  = {{8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};
   wire [15:0]  wr_mask  = be_mask & ADV_WR_MASK;            // [R5] [R10] [R12]
   wire         exp_clr  = rd & hit_exp;                       // [R21]

   wire [15:0]  rd_id_hi = ID_OUI_HIGH;                        // [R1]
   wire [15:0]  rd_id_lo = {ID_OUI_LOW, ID_MODEL, ID_REV};      // [R2] [R3] [R4]
   wire [15:0]  rd_adv   = adv_r | {11'h000, SEL_8023};         // [R12]
   wire [15:0]  rd_exp   = {11'h000, pdf_r, i_an.np_able, 1'b0,
                            prx_r, i_an.an_able};              // [R17] [R19]
   wire [15:0]  rd_val   = (idx == IDX_ID_HIGH) ? rd_id_hi :
                           (idx == IDX_ID_LOW)  ? rd_id_lo :
                           hit_adv              ? rd_adv   :
                           (idx == IDX_LPA)     ? lpa_r    :
                           hit_exp              ? rd_exp   :
                                                  16'h0000;

   // -----------------------------------------------------------------
   // next values
   // -----------------------------------------------------------------
   assign adv_nxt = (wr & hit_adv) ?
                    ((adv_r & ~wr_mask) | (i_wb.dat[15:0] & wr_mask)) :
                    adv_r;                       // [R6] [R7] [R9] [R11]
   assign pdf_nxt = i_an.parallel_fault | (pdf_r & ~exp_clr);  // [R16]
   assign prx_nxt = i_an.word_valid | (prx_r & ~exp_clr);      // [R18]

   // -----------------------------------------------------------------
   // bus answer
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= req;
         if (rd)
            dat_r <= {16'h0000, rd_val};
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         adv_r  <= ADV_RESET;                                  // [R7] [R11]
         act_r  <= ADV_RESET | {11'h000, SEL_8023};
         lpa_r  <= 16'h0000;                                   // [R14]
         pdf_r  <= 1'b0;
         prx_r  <= 1'b0;
         stat_r <= LOCAL_ABILITY;                              // [R20]
      end
      else
      begin
         adv_r  <= adv_nxt;
         pdf_r  <= pdf_nxt;
         prx_r  <= prx_nxt;
         stat_r <= LOCAL_ABILITY;                              // [R20]
         if (i_an.restart)
            act_r <= rd_adv;                                   // [R8]
         if (i_an.word_valid)
            lpa_r <= i_an.word;                                // [R13] [R14] [R15]
      end
   end

   assign o_wb_ack         = ack_r;
   assign o_wb_dat         = dat_r;
   assign o_adv_word       = act_r;
   assign o_status_ability = stat_r;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_exp_read;
      rd && hit_exp;
   endsequence

   sequence s_no_new_pdf;
      !i_an.parallel_fault;
   endsequence

   sequence s_adv_write;
      wr && hit_adv;
   endsequence

   sequence s_restart;
      i_an.restart;
   endsequence

   sequence s_word_in;
      i_an.word_valid;
   endsequence

   sequence s_fault_in;
      i_an.parallel_fault;
   endsequence

   // -----------------------------------------------------------------
   // bus answer checks
   // -----------------------------------------------------------------
   a_ack_single_cycle: assert property (   // [R21]
      ack_r
      |=> !ack_r)
      else $error("ack held longer than one cycle");

   a_ack_answers_req: assert property (    // [R21]
      req
      |=> ack_r && o_wb_dat[31:16] == 16'h0000)
      else $error("request not answered in one cycle");

   a_ack_no_idle: assert property (        // [R21]
      !req
      |=> !ack_r)
      else $error("ack without request");

   a_ack_from_req: assert property (       // [R21]
      ack_r
      |-> $past(req))
      else $error("ack not preceded by request");

   a_dat_high_zero: assert property (      // [R21]
      o_wb_dat[31:16] == 16'h0000)
      else $error("read data upper half not zero");

   a_dat_hold: assert property (           // [R21]
      !rd
      |=> $stable(o_wb_dat))
      else $error("read data changed without read");

   a_unmapped_read: assert property (      // [R21]
      rd && (idx < IDX_ID_HIGH || idx > IDX_EXP)
      |=> o_wb_dat == 32'h0000_0000)
      else $error("unmapped read not zero");

   // -----------------------------------------------------------------
   // identifier checks
   // -----------------------------------------------------------------
   a_id_high_read: assert property (       // [R1]
      rd && idx == IDX_ID_HIGH
      |=> o_wb_dat == {16'h0000, ID_OUI_HIGH})
      else $error("identifier high read wrong");

   a_id_low_read: assert property (        // [R2] [R3] [R4]
      rd && idx == IDX_ID_LOW
      |=> o_wb_dat[15:4] == {ID_OUI_LOW, ID_MODEL}
          && o_wb_dat[3:0] == ID_REV)
      else $error("identifier low read wrong");

   // -----------------------------------------------------------------
   // advertisement checks
   // -----------------------------------------------------------------
   a_adv_fixed_bits: assert property (     // [R5] [R10] [R12]
      rd && hit_adv
      |=> o_wb_dat[15:14] == 2'b00 && o_wb_dat[12] == 1'b0
          && o_wb_dat[9] == 1'b0 && o_wb_dat[4:0] == SEL_8023)
      else $error("advertisement fixed bits wrong");

   a_adv_ro_store: assert property (       // [R5] [R10]
      adv_r[15:14] == 2'b00 && adv_r[12] == 1'b0
      && adv_r[9] == 1'b0 && adv_r[4:0] == 5'h00)
      else $error("read-only advertisement bits stored");

   a_adv_write_store: assert property (    // [R6] [R9] [R11]
      s_adv_write ##0 i_wb.sel[1:0] == 2'b11
      |=> adv_r == ($past(i_wb.dat[15:0]) & ADV_WR_MASK))
      else $error("advertisement write not stored");

   a_adv_low_byte: assert property (       // [R11]
      s_adv_write ##0 i_wb.sel[1:0] == 2'b01
      |=> adv_r[15:8] == $past(adv_r[15:8])
          && adv_r[7:5] == $past(i_wb.dat[7:5]))
      else $error("low byte write wrong");

   a_adv_high_byte: assert property (      // [R6] [R9] [R11]
      s_adv_write ##0 i_wb.sel[1:0] == 2'b10
      |=> adv_r[7:0] == $past(adv_r[7:0])
          && adv_r[13] == $past(i_wb.dat[13])
          && adv_r[11:10] == $past(i_wb.dat[11:10])
          && adv_r[8] == $past(i_wb.dat[8]))
      else $error("high byte write wrong");

   a_adv_idle_hold: assert property (      // [R7]
      !(wr && hit_adv)
      |=> $stable(adv_r))
      else $error("advertisement changed without write");

   a_adv_read_stored: assert property (    // [R8]
      rd && hit_adv
      |=> o_wb_dat[13:5] == $past(adv_r[13:5]))
      else $error("stored advertisement not readable");

   a_rd_no_adv_change: assert property (   // [R21]
      rd
      |=> $stable(adv_r))
      else $error("read changed advertisement");

   // -----------------------------------------------------------------
   // active advertised word checks
   // -----------------------------------------------------------------
   a_adv_write_held: assert property (     // [R8]
      !i_an.restart
      |=> $stable(o_adv_word))
      else $error("advertised word changed without restart");

   a_act_no_wr_effect: assert property (   // [R8]
      s_adv_write ##0 !i_an.restart
      |=> $stable(o_adv_word))
      else $error("write reached advertised word");

   a_adv_restart_load: assert property (   // [R8]
      s_restart ##1 !i_an.restart
      |-> o_adv_word == ($past(adv_r) | {11'h000, SEL_8023}))
      else $error("restart did not load advertisement");

   a_act_fixed_bits: assert property (     // [R5] [R10] [R12]
      o_adv_word[15:14] == 2'b00 && o_adv_word[12] == 1'b0
      && o_adv_word[9] == 1'b0 && o_adv_word[4:0] == SEL_8023)
      else $error("advertised word fixed bits wrong");

   // -----------------------------------------------------------------
   // status ability checks
   // -----------------------------------------------------------------
   a_status_fixed: assert property (       // [R20]
      o_status_ability == LOCAL_ABILITY)
      else $error("status ability not fixed");

   a_status_stable: assert property (      // [R20]
      $stable(o_status_ability))
      else $error("status ability changed");

   // -----------------------------------------------------------------
   // partner checks
   // -----------------------------------------------------------------
   a_lpa_load: assert property (           // [R14] [R18]
      s_word_in
      |=> lpa_r == $past(i_an.word) && prx_r)
      else $error("partner word not loaded");

   a_lpa_hold: assert property (           // [R13] [R14]
      !i_an.word_valid
      |=> $stable(lpa_r))
      else $error("partner word changed without load");

   a_lpa_read: assert property (           // [R13] [R14] [R15]
      rd && idx == IDX_LPA
      |=> o_wb_dat[15:0] == $past(lpa_r))
      else $error("partner read wrong");

   // -----------------------------------------------------------------
   // expansion flag checks
   // -----------------------------------------------------------------
   a_pdf_latch: assert property (          // [R16]
      s_fault_in
      |=> pdf_r)
      else $error("parallel fault not latched");

   a_pdf_read_clear: assert property (     // [R16] [R21]
      s_exp_read ##0 s_no_new_pdf
      |=> !pdf_r && o_wb_ack)
      else $error("parallel fault not cleared by read");

   a_pdf_set_wins: assert property (       // [R16]
      s_exp_read ##0 s_fault_in
      |=> pdf_r)
      else $error("fault lost against read clear");

   a_pdf_hold: assert property (           // [R16]
      pdf_r && !exp_clr
      |=> pdf_r)
      else $error("parallel fault dropped without read");

   a_pdf_no_spurious: assert property (    // [R16]
      !pdf_r && !i_an.parallel_fault
      |=> !pdf_r)
      else $error("parallel fault set without event");

   a_prx_read_clear: assert property (     // [R18]
      s_exp_read ##0 !i_an.word_valid
      |=> !prx_r)
      else $error("page received not cleared by read");

   a_prx_set_wins: assert property (       // [R18]
      s_exp_read ##0 s_word_in
      |=> prx_r)
      else $error("page received lost against read clear");

   a_prx_hold: assert property (           // [R18]
      prx_r && !exp_clr
      |=> prx_r)
      else $error("page received dropped without read");

   a_prx_no_spurious: assert property (    // [R18]
      !prx_r && !i_an.word_valid
      |=> !prx_r)
      else $error("page received set without word");

   a_word_then_read: assert property (     // [R18]
      s_word_in ##1 s_exp_read
      |=> o_wb_dat[1])
      else $error("page received not read back");

   a_fault_then_read: assert property (    // [R16]
      s_fault_in ##1 s_exp_read
      |=> o_wb_dat[4])
      else $error("parallel fault not read back");

   a_exp_read_bits: assert property (      // [R17] [R19]
      rd && hit_exp
      |=> o_wb_dat[15:5] == 11'h000 && o_wb_dat[2] == 1'b0
          && o_wb_dat[0] == $past(i_an.an_able))
      else $error("expansion read bits wrong");

   a_exp_live_bits: assert property (      // [R16] [R17] [R18]
      s_exp_read
      |=> o_wb_dat[3] == $past(i_an.np_able)
          && o_wb_dat[4] == $past(pdf_r)
          && o_wb_dat[1] == $past(prx_r))
      else $error("expansion flag bits wrong");

endmodule
`default_nettype wire

// File: verif/pianr_an_model.sv
`timescale 1ns/1ps
`default_nettype none
module pianr_an_model
(
   // clock
   input  wire logic                 i_sys_clk,
   // events towards the register block
   output var pianr_pkg::pianr_an_evt_t o_an
);
   import pianr_pkg::*;
   initial o_an = '0;
   // one-cycle event; word line scrambled once released
   task automatic evt(input logic [15:0] w, input logic v, input logic f,
                      input logic r);
   begin
      @(posedge i_sys_clk);
      o_an.word_valid     <= v;
      o_an.word           <= w;
      o_an.parallel_fault <= f;
      o_an.restart        <= r;
      @(posedge i_sys_clk);
      o_an.word_valid     <= 1'b0;
      o_an.word           <= ~w;
      o_an.parallel_fault <= 1'b0;
      o_an.restart        <= 1'b0;
   end
   endtask
   // partner capability levels
   task automatic lvl(input logic a, input logic n);
   begin
      @(posedge i_sys_clk);
      o_an.an_able <= a;
      o_an.np_able <= n;
   end
   endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pianr_pkg::*;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   pianr_wb_req_t wb = '0;
   logic          ack;
   logic [31:0]   rdat;
   pianr_an_evt_t an_evt;
   logic [15:0]   adv_word;
   logic [4:0]    st_ab;
   logic [15:0]   q;
   int            err_total = 0;
   int            samples_checked = 0;
   always #4 clk = ~clk;
   pianr_regs uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_wb(wb),
      .o_wb_ack(ack), .o_wb_dat(rdat), .i_an(an_evt),
      .o_adv_word(adv_word), .o_status_ability(st_ab));
   pianr_an_model an (.i_sys_clk(clk), .o_an(an_evt));
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, e);
   begin
      samples_checked++;
      if (s !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   end
   endtask
   task automatic bus(input logic w, input logic [5:0] idx,
                      input logic [15:0] d);
      int n;
   begin
      n = 0;
      @(posedge clk);
      wb <= '{cyc:1'b1, stb:1'b1, we:w, adr:{idx, 2'b00}, sel:4'h3,
              dat:{16'h0000, d}};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      q = rdat[15:0];
      wb <= '0;
      if (n >= 50)
         chk("ack", 32'h0, 32'h1);
   end
   endtask
   task automatic rd(input string nm, input logic [5:0] i,
                     input logic [15:0] e);
   begin
      bus(1'b0, i, 16'h0000);
      chk(nm, {16'h0000, q}, {16'h0000, e});
   end
   endtask
   task automatic summarize;
   begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset;
   begin
      rd("id_high", IDX_ID_HIGH, ID_OUI_HIGH);
      rd("id_low", IDX_ID_LOW, {ID_OUI_LOW, ID_MODEL, ID_REV});
      rd("adv", IDX_ADV, 16'h01e1);
      rd("lpa", IDX_LPA, 16'h0000);
      rd("exp", IDX_EXP, 16'h0000);
      rd("unmapped", 6'h07, 16'h0000);
      chk("adv_word", {16'h0000, adv_word}, 32'h01e1);
      chk("status_ab", {27'h0, st_ab}, 32'h0f);
   end
   endtask
   task automatic t_adv;
   begin
      bus(1'b1, IDX_ID_HIGH, 16'h1234);
      rd("id_ro", IDX_ID_HIGH, ID_OUI_HIGH);
      bus(1'b1, IDX_ADV, 16'hffff);
      rd("adv_ones", IDX_ADV, 16'h2de1);
      chk("adv_hold", {16'h0000, adv_word}, 32'h01e1);
      an.evt(16'h0000, 1'b0, 1'b0, 1'b1);
      @(posedge clk);
      #1 chk("adv_new", {16'h0000, adv_word}, 32'h2de1);
      bus(1'b1, IDX_ADV, 16'h0000);
      rd("adv_zero", IDX_ADV, 16'h0001);
   end
   endtask
   task automatic t_partner;
   begin
      an.lvl(1'b1, 1'b1);
      an.evt(16'hc5e1, 1'b1, 1'b0, 1'b0);
      rd("lpa_word", IDX_LPA, 16'hc5e1);
      rd("exp_prx", IDX_EXP, 16'h000b);
      rd("exp_clr", IDX_EXP, 16'h0009);
      an.evt(16'h0000, 1'b0, 1'b1, 1'b0);
      rd("exp_pdf", IDX_EXP, 16'h0019);
      an.lvl(1'b0, 1'b0);
      rd("exp_pdf_clr", IDX_EXP, 16'h0000);
   end
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_adv();
      t_partner();
      summarize();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      err_total++;
      summarize();
   end
endmodule
`default_nettype wire
